// File: logic/wdrat_top.sv
// Watchdog reset path and instruction-fetch address trap with APB registers
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module wdrat_top #(
  parameter int unsigned PRE_W = wdrat_pkg::DEF_PRE_W,
  parameter int unsigned TAP_BASE = wdrat_pkg::DEF_TAP_BASE,
  parameter logic [15:0] SFR_LO = wdrat_pkg::DEF_SFR_LO,
  parameter logic [15:0] SFR_HI = wdrat_pkg::DEF_SFR_HI,
  parameter logic [15:0] RAM_LO = wdrat_pkg::DEF_RAM_LO,
  parameter logic [15:0] RAM_HI = wdrat_pkg::DEF_RAM_HI,
  parameter logic [15:0] DBR_LO = wdrat_pkg::DEF_DBR_LO,
  parameter logic [15:0] DBR_HI = wdrat_pkg::DEF_DBR_HI
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire wdrat_pkg::wdrat_apb_req_t apb_req,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire wdrat_pkg::wdrat_fetch_t fetch,
  input wire logic low_speed_mode_one,
  input wire logic sub_oscillator_clock_tick,
  input wire logic hold_mode,
  output logic reset_pin_n,
  output logic hw_reset,
  output logic osc_restart,
  output logic overflow_interrupt,
  output logic fetch_trap_interrupt
);
  import wdrat_pkg::*;

  logic rst_meta_r;
  logic rst_n;
  logic pready_r;
  logic [31:0] prdata_r;
  logic pslverr_r;
  logic [1:0] wdtt_r;
  logic guard_enable_r;
  logic trap_action_r;
  logic ram_trap_pending_r;
  logic ovf_action_r;
  logic ram_trap_eff_r;
  logic guard_active_r;
  logic [PRE_W-1:0] prescaler_r;
  logic [1:0] bin_cnt_r;
  logic [RST_CNT_W-1:0] rst_cnt_r;
  logic [RST_CNT_W-1:0] rst_cnt_nxt;
  logic [1:0] cause_r;
  logic reset_pin_n_r;
  logic hw_reset_r;
  logic osc_restart_r;
  logic ovf_irq_r;
  logic trap_irq_r;

  function automatic wdrat_sel_t reg_sel(input logic [ADDR_W-1:0] a);
    if (a == ADDR_CTRL1) begin
      return SEL_CTRL1;
    end else if (a == ADDR_CMD) begin
      return SEL_CMD;
    end else if (a == ADDR_STATUS) begin
      return SEL_STATUS;
    end else begin
      return SEL_NONE;
    end
  endfunction : reg_sel

  function automatic logic in_area(input logic [15:0] a, input logic [15:0] lo,
                                   input logic [15:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction : in_area

  function automatic logic tap_hit(input logic [PRE_W-1:0] pre, input logic [1:0] sel);
    int unsigned t;
    logic [PRE_W-1:0] m;
    t = TAP_BASE + 2 * (WDTT_MAX - sel);
    m = ~({PRE_W{1'b1}} << (t + 1));
    return (pre & m) == m;
  endfunction : tap_hit

  // Reset release through two flops
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n <= rst_meta_r;
    end
  end

  // Bus decode; one wait-free access phase
  wire logic apb_setup = apb_req.psel && !apb_req.penable;
  wire logic apb_done = apb_req.psel && apb_req.penable && pready_r;
  wire wdrat_sel_t sel = reg_sel(apb_req.paddr);
  wire logic ctrl1_wr = apb_done && apb_req.pwrite && (sel == SEL_CTRL1);
  wire logic cmd_wr = apb_done && apb_req.pwrite && (sel == SEL_CMD);
  wire logic [7:0] wbyte = apb_req.pwdata[7:0];
  wire logic cmd_apply = cmd_wr && (wbyte == CODE_TRAP_APPLY);
  wire logic cmd_clear = cmd_wr && (wbyte == CODE_CLEAR);
  wire logic cmd_disable = cmd_wr && (wbyte == CODE_DISABLE);

  // Watchdog stepping and overflow
  wire logic pulse_busy = (rst_cnt_r != '0);
  wire logic step = guard_active_r && !hold_mode &&
                    (low_speed_mode_one ? sub_oscillator_clock_tick : 1'b1);
  wire logic bin_tick = step && tap_hit(prescaler_r, wdtt_r);
  wire logic ovf = bin_tick && (bin_cnt_r == BIN_LAST) && !cmd_clear;

  // Address trap detection
  wire logic in_ram = in_area(fetch.addr, RAM_LO, RAM_HI);
  wire logic in_fixed = in_area(fetch.addr, SFR_LO, SFR_HI) ||
                        in_area(fetch.addr, DBR_LO, DBR_HI);
  wire logic trap_hit = fetch.valid && (in_fixed || (ram_trap_eff_r && in_ram));

  // New requests are ignored while a pulse runs; the device is being reset anyway
  wire logic wdt_rst_req = ovf && ovf_action_r && !pulse_busy;
  wire logic trap_rst_req = trap_hit && trap_action_r && !pulse_busy;
  wire logic rst_req = wdt_rst_req || trap_rst_req;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= apb_setup;
      if (apb_setup) begin
        pslverr_r <= (sel == SEL_NONE);
        if (!apb_req.pwrite && (sel == SEL_STATUS)) begin
          prdata_r <= wdrat_status_t'{zero: 22'h00_0000, wdtt: wdtt_r, cause: cause_r,
                                      bin_cnt: bin_cnt_r, ovf_action: ovf_action_r,
                                      trap_action: trap_action_r,
                                      ram_trap: ram_trap_eff_r, active: guard_active_r};
        end else begin
          prdata_r <= 32'h0000_0000;
        end
      end else if (apb_done) begin
        pslverr_r <= 1'b0;
        prdata_r <= 32'h0000_0000;
      end
    end
  end

  // Control register one; a reset request restores it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wdtt_r <= CTRL1_RESET[BIT_WDTT_LSB +: 2];
      guard_enable_r <= CTRL1_RESET[BIT_ENABLE];
      trap_action_r <= CTRL1_RESET[BIT_TRAP_ACTION];
      ram_trap_pending_r <= CTRL1_RESET[BIT_RAM_TRAP];
      ovf_action_r <= CTRL1_RESET[BIT_OVF_ACTION];
    end else if (rst_req) begin
      wdtt_r <= CTRL1_RESET[BIT_WDTT_LSB +: 2];
      guard_enable_r <= CTRL1_RESET[BIT_ENABLE];
      trap_action_r <= CTRL1_RESET[BIT_TRAP_ACTION];
      ram_trap_pending_r <= CTRL1_RESET[BIT_RAM_TRAP];
      ovf_action_r <= CTRL1_RESET[BIT_OVF_ACTION];
    end else if (ctrl1_wr) begin
      wdtt_r <= wbyte[BIT_WDTT_LSB +: 2];
      guard_enable_r <= wbyte[BIT_ENABLE];
      trap_action_r <= wbyte[BIT_TRAP_ACTION];
      ram_trap_pending_r <= wbyte[BIT_RAM_TRAP];
      // Once cleared, software cannot set it again
      ovf_action_r <= ovf_action_r && wbyte[BIT_OVF_ACTION];
    end
  end

  // RAM trap setting becomes live only on the apply code
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ram_trap_eff_r <= CTRL1_RESET[BIT_RAM_TRAP];
    end else if (rst_req) begin
      ram_trap_eff_r <= CTRL1_RESET[BIT_RAM_TRAP];
    end else if (cmd_apply) begin
      ram_trap_eff_r <= ram_trap_pending_r;
    end
  end

  // Running state: enable bit sets it, disable code clears it only while the enable bit is zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      guard_active_r <= CTRL1_RESET[BIT_ENABLE];
    end else if (rst_req) begin
      guard_active_r <= CTRL1_RESET[BIT_ENABLE];
    end else if (ctrl1_wr && wbyte[BIT_ENABLE]) begin
      guard_active_r <= 1'b1;
    end else if (cmd_disable && !guard_enable_r) begin
      guard_active_r <= 1'b0;
    end
  end

  // Prescaler and two-stage binary counter
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prescaler_r <= '0;
    end else if (rst_req || !guard_active_r) begin
      prescaler_r <= '0;
    end else if (step) begin
      prescaler_r <= prescaler_r + PRE_W'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bin_cnt_r <= 2'h0;
    end else if (rst_req || !guard_active_r || cmd_clear) begin
      bin_cnt_r <= 2'h0;
    end else if (bin_tick) begin
      bin_cnt_r <= bin_cnt_r + 2'h1;
    end
  end

  // Reset pulse timing on the main clock
  always_comb begin
    rst_cnt_nxt = rst_cnt_r;
    if (rst_req) begin
      rst_cnt_nxt = RST_CNT_W'(RESET_CYCLES);
    end else if (pulse_busy) begin
      rst_cnt_nxt = rst_cnt_r - RST_CNT_W'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_cnt_r <= '0;
      reset_pin_n_r <= 1'b1;
      hw_reset_r <= 1'b0;
      osc_restart_r <= 1'b0;
    end else begin
      rst_cnt_r <= rst_cnt_nxt;
      reset_pin_n_r <= (rst_cnt_nxt == '0);
      hw_reset_r <= (rst_cnt_nxt != '0);
      // Slow mode: main oscillator restarted for the pulse
      osc_restart_r <= (rst_cnt_nxt != '0) && low_speed_mode_one;
    end
  end

  // Last reset cause, readable after the pulse
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cause_r <= 2'h0;
    end else if (rst_req) begin
      cause_r <= {trap_rst_req, wdt_rst_req};
    end
  end

  // Non-maskable requests; nesting priority sits in the interrupt controller
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ovf_irq_r <= 1'b0;
      trap_irq_r <= 1'b0;
    end else begin
      ovf_irq_r <= ovf && !ovf_action_r && !pulse_busy;
      trap_irq_r <= trap_hit && !trap_action_r && !pulse_busy;
    end
  end

  assign pready = pready_r;
  assign prdata = prdata_r;
  assign pslverr = pslverr_r;
  assign reset_pin_n = reset_pin_n_r;
  assign hw_reset = hw_reset_r;
  assign osc_restart = osc_restart_r;
  assign overflow_interrupt = ovf_irq_r;
  assign fetch_trap_interrupt = trap_irq_r;

  // Helper: length of the current low pulse
  logic [RST_CNT_W:0] low_len_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      low_len_r <= '0;
    end else if (reset_pin_n_r) begin
      low_len_r <= '0;
    end else begin
      low_len_r <= low_len_r + (RST_CNT_W + 1)'(1);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_pin_low_two;
    !reset_pin_n_r [*2];
  endsequence

  sequence s_pin_low_hw;
    !reset_pin_n_r && hw_reset_r;
  endsequence

  AST_OVF_RESET: assert property (wdt_rst_req |=> s_pin_low_two)
    else $error("Overflow in reset mode did not pull the pin low");

  AST_HW_RESET: assert property (rst_req |=> s_pin_low_hw)
    else $error("Reset request did not reset hardware");

  AST_PULSE_LEN: assert property (low_len_r <= (RST_CNT_W + 1)'(RESET_CYCLES))
    else $error("Reset pulse too long");

  AST_SLOW_OSC: assert property (rst_req && low_speed_mode_one |=> osc_restart_r)
    else $error("Slow mode reset did not restart oscillator");

  AST_CLEAR: assert property (cmd_clear && !rst_req |=> bin_cnt_r == 2'h0)
    else $error("Clear code did not clear binary counter");

  AST_RAM_APPLY: assert property (!cmd_apply && !rst_req |=> $stable(ram_trap_eff_r))
    else $error("RAM trap setting changed without apply code");

  AST_FIXED_TRAP: assert property (fetch.valid && in_fixed && !trap_action_r && !pulse_busy
                                   |=> trap_irq_r)
    else $error("Register or debug area fetch did not trap");

  AST_TRAP_RESET: assert property (trap_rst_req |=> !reset_pin_n_r && !trap_irq_r)
    else $error("Trap in reset mode did not reset");

  AST_DISABLE: assert property (cmd_disable && !guard_enable_r && !rst_req
                                |=> !guard_active_r)
    else $error("Disable code ignored with enable at zero");

  AST_OVF_IRQ: assert property (ovf && !ovf_action_r && !pulse_busy
                                |=> ovf_irq_r ##1 !ovf_irq_r)
    else $error("Overflow interrupt not a single pulse");

  AST_PAUSE: assert property (hold_mode && guard_active_r && !rst_req && !ctrl1_wr
                              && !cmd_wr |=> $stable(prescaler_r))
    else $error("Prescaler moved during hold");

endmodule : wdrat_top

`default_nettype wire

// File: logic/wdrat_pkg.sv
// Shared constants and types for the watchdog reset and address-trap block
package wdrat_pkg;
  // Clock figures and reset pulse length
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned FC_PERIOD_NS = 10;
  localparam int unsigned RESET_FC_PERIODS = 24;
  // Longest time: rounded down
  localparam int unsigned RESET_CYCLES = (RESET_FC_PERIODS * FC_PERIOD_NS) / CLK_PERIOD_NS;
  localparam int unsigned RST_CNT_W = 5;

  // Register indices; byte address is four times the index
  localparam int unsigned ADDR_W = 12;
  localparam logic [9:0] IDX_CTRL1 = 10'h034;
  localparam logic [9:0] IDX_CMD = 10'h035;
  localparam logic [9:0] IDX_STATUS = 10'h036;
  localparam logic [ADDR_W-1:0] ADDR_CTRL1 = {IDX_CTRL1, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_CMD = {IDX_CMD, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_STATUS = {IDX_STATUS, 2'b00};

  // Command codes
  localparam logic [7:0] CODE_TRAP_APPLY = 8'hD2;
  localparam logic [7:0] CODE_CLEAR = 8'h4E;
  localparam logic [7:0] CODE_DISABLE = 8'hB1;

  // Control register one fields
  localparam int unsigned BIT_OVF_ACTION = 0;
  localparam int unsigned BIT_WDTT_LSB = 1;
  localparam int unsigned BIT_ENABLE = 3;
  localparam int unsigned BIT_TRAP_ACTION = 4;
  localparam int unsigned BIT_RAM_TRAP = 5;
  localparam logic [7:0] CTRL1_RESET = 8'h39;

  // Prescaler shape: tap = base + 2 * (3 - select)
  localparam int unsigned DEF_PRE_W = 24;
  localparam int unsigned DEF_TAP_BASE = 17;
  localparam int unsigned WDTT_MAX = 3;
  localparam logic [1:0] BIN_LAST = 2'h3;

  // Neutral default area bounds
  localparam logic [15:0] DEF_SFR_LO = 16'h0000;
  localparam logic [15:0] DEF_SFR_HI = 16'h003F;
  localparam logic [15:0] DEF_RAM_LO = 16'h0040;
  localparam logic [15:0] DEF_RAM_HI = 16'h023F;
  localparam logic [15:0] DEF_DBR_LO = 16'h0F80;
  localparam logic [15:0] DEF_DBR_HI = 16'h0FFF;

  typedef enum logic [1:0] {
    SEL_NONE = 2'b00,
    SEL_CTRL1 = 2'b01,
    SEL_CMD = 2'b10,
    SEL_STATUS = 2'b11
  } wdrat_sel_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } wdrat_apb_req_t;

  typedef struct packed {
    logic valid;
    logic [15:0] addr;
  } wdrat_fetch_t;

  typedef struct packed {
    logic [21:0] zero;
    logic [1:0] wdtt;
    logic [1:0] cause;
    logic [1:0] bin_cnt;
    logic ovf_action;
    logic trap_action;
    logic ram_trap;
    logic active;
  } wdrat_status_t;
endpackage : wdrat_pkg

// File: tb/wdrat_fetch_model.sv
// Instruction fetch source standing in for the CPU core
`timescale 1ns/1ps
`default_nettype none
module wdrat_fetch_model (
  input wire logic clk,
  output wdrat_pkg::wdrat_fetch_t fetch
);
  import wdrat_pkg::*;
  initial fetch = '{valid: 1'b0, addr: 16'h5A5A};
  // Idle bus shows the inverse address, never a stale copy
  task automatic fetch_once(input logic [15:0] a);
    @(posedge clk);
    fetch <= '{valid: 1'b1, addr: a};
    @(posedge clk);
    fetch <= '{valid: 1'b0, addr: ~a};
  endtask : fetch_once
endmodule : wdrat_fetch_model
`default_nettype wire

// File: tb/test_watchdog_reset_and_address_trap.sv
// Register-level testbench for the watchdog reset and address-trap block
`timescale 1ns/1ps
`default_nettype none
module test_watchdog_reset_and_address_trap;
  import wdrat_pkg::*;
  logic clk, arst_n, slow, hold, pready, pslverr, rst_n, hw_rst, osc, ovf_irq, trap_irq, err;
  // Low pin cycles seen so far; a quiet stretch leaves it unchanged
  int low_cycles = 0;
  // Low-frequency tick every other cycle, so slow mode stepping is exercised
  logic sub_tick = 1'b0;
  logic [31:0] prdata, rdata;
  wdrat_apb_req_t req;
  wdrat_fetch_t fw;
  int n_mismatch = 0;
  int checks_done = 0;

  wdrat_fetch_model fm (.clk(clk), .fetch(fw));
  // Short prescaler keeps an overflow near a thousand cycles
  wdrat_top #(.PRE_W(8), .TAP_BASE(1)) dut (.clk(clk), .arst_n(arst_n), .apb_req(req),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .fetch(fw),
    .low_speed_mode_one(slow), .sub_oscillator_clock_tick(sub_tick), .hold_mode(hold),
    .reset_pin_n(rst_n), .hw_reset(hw_rst), .osc_restart(osc),
    .overflow_interrupt(ovf_irq), .fetch_trap_interrupt(trap_irq));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) if (rst_n === 1'b0) low_cycles <= low_cycles + 1;
  always @(posedge clk) sub_tick <= ~sub_tick;

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk);
    req.penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (pready !== 1'b1) begin
      chk(32'h0, 32'h1);
      give_verdict();
    end
    rdata = prdata;
    err = pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdata, exp);
  endtask : rd

  task automatic trap(input logic [15:0] a, input logic exp);
    fm.fetch_once(a);
    #1;
    chk({31'h0, trap_irq}, {31'h0, exp});
  endtask : trap

  // Finds the next reset pulse and measures it cycle by cycle
  task automatic pulse(input int lim, input logic slw);
    int i;
    int n;
    for (i = 0; i < lim; i++) begin
      #1;
      if (rst_n === 1'b0) break;
      @(posedge clk);
    end
    if (rst_n !== 1'b0) begin
      chk(32'h0, 32'h1);
      give_verdict();
    end
    n = 0;
    while (rst_n === 1'b0 && n < 40) begin
      chk({31'h0, hw_rst}, 32'h1);
      chk({31'h0, osc}, {31'h0, slw});
      n++;
      @(posedge clk);
      #1;
    end
    chk(32'(n), 32'(RESET_CYCLES));
  endtask : pulse

  initial begin
    int i;
    int base;
    req = '0;
    slow = 1'b0;
    hold = 1'b0;
    arst_n = 1'b0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd(ADDR_STATUS, 32'h0000_000F);
    rd(ADDR_CTRL1, 32'h0);
    rd(12'h0FC, 32'h0);
    chk({31'h0, err}, 32'h1);
    $display("test map done");
    apb(1'b1, ADDR_CMD, 32'h4E);
    apb(1'b1, ADDR_CMD, 32'hB1);
    rd(ADDR_STATUS, 32'h0000_000F);
    apb(1'b1, ADDR_CTRL1, 32'h31);
    apb(1'b1, ADDR_CMD, 32'hB1);
    rd(ADDR_STATUS, 32'h0000_000E);
    $display("test disable done");
    apb(1'b1, ADDR_CTRL1, 32'h21);
    trap(16'h0010, 1'b1);
    @(posedge clk);
    #1;
    chk({31'h0, trap_irq}, 32'h0);
    trap(16'h0100, 1'b1);
    trap(16'h0F90, 1'b1);
    trap(16'h0800, 1'b0);
    apb(1'b1, ADDR_CTRL1, 32'h01);
    trap(16'h0100, 1'b1);
    apb(1'b1, ADDR_CMD, 32'hD2);
    trap(16'h0100, 1'b0);
    trap(16'h0020, 1'b1);
    rd(ADDR_STATUS, 32'h0000_0008);
    $display("test trap irq done");
    apb(1'b1, ADDR_CTRL1, 32'h11);
    slow <= 1'b1;
    fm.fetch_once(16'h0010);
    pulse(3, 1'b1);
    slow <= 1'b0;
    rd(ADDR_STATUS, 32'h0000_008F);
    $display("test trap reset done");
    pulse(1300, 1'b0);
    rd(ADDR_STATUS, 32'h0000_004F);
    $display("test overflow reset done");
    base = low_cycles;
    for (i = 0; i < 4; i++) begin
      repeat (600) @(posedge clk);
      apb(1'b1, ADDR_CMD, 32'h4E);
    end
    chk(32'(low_cycles), 32'(base));
    $display("test clear done");
    // Longer than one overflow period; only the pause keeps the pin high
    hold <= 1'b1;
    repeat (1300) @(posedge clk);
    hold <= 1'b0;
    apb(1'b1, ADDR_CMD, 32'h4E);
    chk(32'(low_cycles), 32'(base));
    $display("test hold done");
    // Shortest detection select: overflow within a few dozen cycles
    apb(1'b1, ADDR_CTRL1, 32'h3E);
    for (i = 0; i < 40; i++) begin
      @(posedge clk);
      #1;
      if (ovf_irq === 1'b1) break;
    end
    chk({31'h0, ovf_irq}, 32'h1);
    chk({31'h0, rst_n}, 32'h1);
    @(posedge clk);
    #1;
    chk({31'h0, ovf_irq}, 32'h0);
    $display("test overflow irq done");
    give_verdict();
  end
endmodule : test_watchdog_reset_and_address_trap
`default_nettype wire
